// ==== comb_fir_pkg.sv ====
// Constants shared by the comb and FIR channel back end.
// Assumes a single 200 MHz clock and APB register access with 32-bit data.
package comb_fir_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_COEF_LAST = 8'h7f;
    localparam logic [7:0] IDX_FIR_DEC = 8'ha0;
    localparam logic [7:0] IDX_FIR_PHASE = 8'ha1;
    localparam logic [7:0] IDX_FIR_TAPS = 8'ha2;
    localparam logic [7:0] IDX_FIR_OFFSET = 8'ha3;
    localparam logic [7:0] IDX_FIR_CONTROL = 8'ha4;
    localparam logic [7:0] IDX_COMB_CONFIG = 8'hb0;
    localparam logic [7:0] IDX_STATUS = 8'hb1;
    // Field positions
    localparam int POS_PAGE = 8;
    localparam int POS_COMB_SCALE = 8;
    localparam int POS_CLEAR = 16;
    localparam int POS_WPTR = 8;
    // Values after reset
    localparam logic [5:0] RST_COMB_RATIO = 6'h02;
    localparam logic [4:0] RST_COMB_SCALE = 5'h00;
    localparam logic [7:0] RST_FIR_DEC = 8'h00;
    localparam logic [7:0] RST_FIR_PHASE = 8'h00;
    localparam logic [7:0] RST_FIR_TAPS = 8'h00;
    localparam logic [7:0] RST_FIR_OFFSET = 8'h00;
    // Comb limits
    localparam logic [5:0] COMB_RATIO_MIN = 6'h02;
    localparam logic [5:0] COMB_RATIO_MAX = 6'h20;
    localparam logic [4:0] COMB_SCALE_MAX = 5'h14;
    localparam logic [5:0] COMB_FIXED_SHIFT = 6'h05;
    localparam int COMB_ORDER = 5;
    // Data RAM depth
    localparam logic [7:0] DATA_DEPTH = 8'ha0;
    localparam logic [7:0] TAPS_M1_MAX = 8'h9f;
    // Fractional point of the accumulator output
    localparam int OUT_SHIFT = 15;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MAC = 2'b01,
        ST_CLEAR = 2'b10
    } fir_state_t;
endpackage

// ==== comb_fir_channel.sv ====
// Fifth-order decimating comb stage followed by a RAM-coefficient decimating FIR.
// Assumes the upstream stage runs on pclk and offers at most one sample per cycle,
// and that software keeps the tap count within the cycles available per output.
//
// How it works
// - Comb decimation ratio accepted from 2 to 32, one output per ratio inputs.
// - Five integrators and five combs, unity coefficients, result divided by 2^(scale+5).
// - Comb scale 0..20, each step attenuates by 6 dB more.
// - Comb accepts a sample every clock, covering 80 MHz input.
// - Comb output rate is input rate divided by its ratio.
// - Data RAM keeps 160 newest complex samples, 20-bit I and Q.
// - Coefficient memory holds 256 words of 20 bits.
// - Each cycle one I and one Q product share one coefficient.
// - Each FIR result is a 24-bit I and a 24-bit Q value.
// - FIR ratio is 8-bit field plus one, 1 to 256.
// - FIR decimation counter preloads the phase value, not zero.
// - Tap field holds taps minus one; writes above 159 clamp to 160 taps.
// - Coefficients written via 128-word window, signed 20-bit two's complement.
// - Page bit picks write page; filtering sees one 256-word space.
// - Comb samples fill the data RAM circularly, I and Q halves.
// - Output starts oldest sample times coefficient at offset, ends offset+taps-1.
// - Lower coefficient addresses multiply older samples.
// - Page bit clear writes taps 0..127, set writes 128..255.
`timescale 1ns/1ps
module comb_fir_channel
    import comb_fir_pkg::*;
#(
    parameter int DATA_W = 20,
    parameter int COEF_W = 20,
    parameter int OUT_W = 24,
    parameter int ACC_W = 48,
    parameter int INT_W = 45
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    input wire logic [DATA_W-1:0] in_i,
    input wire logic [DATA_W-1:0] in_q,
    output logic out_valid,
    output logic [OUT_W-1:0] out_i,
    output logic [OUT_W-1:0] out_q
);
    logic [5:0] comb_decimation_ratio;
    logic [4:0] comb_scale_setting;
    logic [7:0] fir_decimation_minus_one;
    logic [7:0] fir_decimation_phase;
    logic [7:0] fir_taps_minus_one;
    logic [7:0] fir_coefficient_start_offset;
    logic page_select;

    logic signed [COEF_W-1:0] coefficient_memory [256];
    logic signed [DATA_W-1:0] mem_i [160];
    logic signed [DATA_W-1:0] mem_q [160];

    fir_state_t state;
    logic [7:0] wptr, rptr, cptr, tap_left, fir_cnt;
    logic signed [ACC_W-1:0] acc_i, acc_q;

    logic [7:0] idx;
    logic acc_phase, wr_en, rd_en;
    assign idx = paddr[9:2];
    assign acc_phase = psel & penable & pready;
    assign wr_en = acc_phase & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    function automatic logic [7:0] ptr_add(input logic [7:0] p, input logic [7:0] d);
        logic [8:0] s;
        s = {1'b0, p} + {1'b0, d};
        if (s >= {1'b0, DATA_DEPTH}) begin
            s = s - {1'b0, DATA_DEPTH};
        end
        return s[7:0];
    endfunction

    function automatic logic [OUT_W-1:0] sat_out(input logic signed [ACC_W-1:0] a);
        logic signed [ACC_W-1:0] t;
        t = a >>> OUT_SHIFT;
        if (t > $signed({{(ACC_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}})) begin
            return {1'b0, {(OUT_W-1){1'b1}}};
        end else if (t < $signed({{(ACC_W-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}})) begin
            return {1'b1, {(OUT_W-1){1'b0}}};
        end
        return t[OUT_W-1:0];
    endfunction

    function automatic logic mapped(input logic [7:0] i);
        return i <= IDX_COEF_LAST || (i >= IDX_FIR_DEC && i <= IDX_FIR_CONTROL)
            || i == IDX_COMB_CONFIG || i == IDX_STATUS;
    endfunction

    // APB slave: no wait state; pready and read data still come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(idx);
            if (rd_en) begin
                if (idx <= IDX_COEF_LAST) begin
                    prdata <= 32'(coefficient_memory[{page_select, idx[6:0]}]);
                end else if (idx == IDX_FIR_DEC) begin
                    prdata <= {24'h00_0000, fir_decimation_minus_one};
                end else if (idx == IDX_FIR_PHASE) begin
                    prdata <= {24'h00_0000, fir_decimation_phase};
                end else if (idx == IDX_FIR_TAPS) begin
                    prdata <= {24'h00_0000, fir_taps_minus_one};
                end else if (idx == IDX_FIR_OFFSET) begin
                    prdata <= {24'h00_0000, fir_coefficient_start_offset};
                end else if (idx == IDX_FIR_CONTROL) begin
                    prdata <= 32'(page_select) << POS_PAGE;
                end else if (idx == IDX_COMB_CONFIG) begin
                    prdata <= (32'(comb_scale_setting) << POS_COMB_SCALE) | 32'(comb_decimation_ratio);
                end else if (idx == IDX_STATUS) begin
                    prdata <= (32'(wptr) << POS_WPTR) | 32'({state == ST_CLEAR, state == ST_MAC});
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end else if (!(psel && penable)) begin
                // Idle and write setup show zero, so a refused write never carries old read data
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comb_decimation_ratio <= RST_COMB_RATIO;
            comb_scale_setting <= RST_COMB_SCALE;
            fir_decimation_minus_one <= RST_FIR_DEC;
            fir_decimation_phase <= RST_FIR_PHASE;
            fir_taps_minus_one <= RST_FIR_TAPS;
            fir_coefficient_start_offset <= RST_FIR_OFFSET;
            page_select <= 1'b0;
        end else if (wr_en) begin
            if (idx == IDX_FIR_DEC) begin
                fir_decimation_minus_one <= pwdata[7:0];
            end else if (idx == IDX_FIR_PHASE) begin
                fir_decimation_phase <= pwdata[7:0];
            end else if (idx == IDX_FIR_TAPS) begin
                // Longer filters than the data RAM are cut to its depth
                fir_taps_minus_one <= (pwdata[7:0] > TAPS_M1_MAX) ? TAPS_M1_MAX : pwdata[7:0];
            end else if (idx == IDX_FIR_OFFSET) begin
                fir_coefficient_start_offset <= pwdata[7:0];
            end else if (idx == IDX_FIR_CONTROL) begin
                page_select <= pwdata[POS_PAGE];
            end else if (idx == IDX_COMB_CONFIG) begin
                // Out-of-range settings are clamped to keep the comb well defined
                if (pwdata[5:0] < COMB_RATIO_MIN) begin
                    comb_decimation_ratio <= COMB_RATIO_MIN;
                end else if (pwdata[5:0] > COMB_RATIO_MAX) begin
                    comb_decimation_ratio <= COMB_RATIO_MAX;
                end else begin
                    comb_decimation_ratio <= pwdata[5:0];
                end
                if (pwdata[POS_COMB_SCALE+4:POS_COMB_SCALE] > COMB_SCALE_MAX) begin
                    comb_scale_setting <= COMB_SCALE_MAX;
                end else begin
                    comb_scale_setting <= pwdata[POS_COMB_SCALE+4:POS_COMB_SCALE];
                end
            end
        end
    end

    // Coefficient memory; the page bit steers APB writes and reads, not the filter
    always_ff @(posedge pclk) begin
        if (wr_en && idx <= IDX_COEF_LAST) begin
            coefficient_memory[{page_select, idx[6:0]}] <= pwdata[COEF_W-1:0];
        end
    end

    // Comb stage: integrators run at the input rate, one sample per clock
    logic signed [INT_W-1:0] integ_i [COMB_ORDER];
    logic signed [INT_W-1:0] integ_q [COMB_ORDER];
    logic signed [INT_W-1:0] dly_i [COMB_ORDER];
    logic signed [INT_W-1:0] dly_q [COMB_ORDER];
    logic signed [INT_W-1:0] stage_i [COMB_ORDER+1];
    logic signed [INT_W-1:0] stage_q [COMB_ORDER+1];
    logic [5:0] comb_cnt;
    logic comb_tick, cmb_valid;
    logic signed [DATA_W-1:0] cmb_i, cmb_q;
    logic [5:0] shift;

    assign comb_tick = in_valid && (comb_cnt == comb_decimation_ratio - 6'h01);
    assign shift = 6'(comb_scale_setting) + COMB_FIXED_SHIFT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comb_cnt <= 6'h00;
        end else if (in_valid) begin
            comb_cnt <= comb_tick ? 6'h00 : comb_cnt + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < COMB_ORDER; k++) begin
                integ_i[k] <= '0;
                integ_q[k] <= '0;
            end
        end else if (in_valid) begin
            // Wraparound arithmetic; the combs undo it exactly
            integ_i[0] <= integ_i[0] + INT_W'($signed(in_i));
            integ_q[0] <= integ_q[0] + INT_W'($signed(in_q));
            for (int k = 1; k < COMB_ORDER; k++) begin
                integ_i[k] <= integ_i[k] + integ_i[k-1];
                integ_q[k] <= integ_q[k] + integ_q[k-1];
            end
        end
    end

    always_comb begin
        stage_i[0] = integ_i[COMB_ORDER-1];
        stage_q[0] = integ_q[COMB_ORDER-1];
        for (int k = 0; k < COMB_ORDER; k++) begin
            stage_i[k+1] = stage_i[k] - dly_i[k];
            stage_q[k+1] = stage_q[k] - dly_q[k];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < COMB_ORDER; k++) begin
                dly_i[k] <= '0;
                dly_q[k] <= '0;
            end
            cmb_valid <= 1'b0;
            cmb_i <= '0;
            cmb_q <= '0;
        end else begin
            cmb_valid <= comb_tick;
            if (comb_tick) begin
                for (int k = 0; k < COMB_ORDER; k++) begin
                    dly_i[k] <= stage_i[k];
                    dly_q[k] <= stage_q[k];
                end
                cmb_i <= DATA_W'(stage_i[COMB_ORDER] >>> shift);
                cmb_q <= DATA_W'(stage_q[COMB_ORDER] >>> shift);
            end
        end
    end

    // Data RAM: circular buffer of comb samples, or zero fill while clearing
    logic clr_req, start;
    logic [7:0] clr_ptr;
    assign clr_req = wr_en && idx == IDX_COMB_CONFIG && pwdata[POS_CLEAR];
    assign start = cmb_valid && fir_cnt == fir_decimation_minus_one && state == ST_IDLE;

    always_ff @(posedge pclk) begin
        if (state == ST_CLEAR) begin
            mem_i[clr_ptr] <= '0;
            mem_q[clr_ptr] <= '0;
        end else if (cmb_valid) begin
            mem_i[wptr] <= cmb_i;
            mem_q[wptr] <= cmb_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr <= 8'h00;
        end else if (state == ST_CLEAR) begin
            wptr <= 8'h00;
        end else if (cmb_valid) begin
            wptr <= ptr_add(wptr, 8'h01);
        end
    end

    // Decimation counter; a phase write restarts decimation from the phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fir_cnt <= RST_FIR_PHASE;
        end else if (wr_en && idx == IDX_FIR_PHASE) begin
            fir_cnt <= pwdata[7:0];
        end else if (cmb_valid) begin
            fir_cnt <= (fir_cnt == fir_decimation_minus_one) ? 8'h00 : fir_cnt + 8'h01;
        end
    end

    logic signed [DATA_W-1:0] di, dq;
    logic signed [COEF_W-1:0] cf;
    assign di = mem_i[rptr];
    assign dq = mem_q[rptr];
    assign cf = coefficient_memory[cptr];

    // MAC sequencer; a wrap during a running sum is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            rptr <= 8'h00;
            cptr <= 8'h00;
            tap_left <= 8'h00;
            clr_ptr <= 8'h00;
            acc_i <= '0;
            acc_q <= '0;
            out_valid <= 1'b0;
            out_i <= '0;
            out_q <= '0;
        end else begin
            out_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (clr_req) begin
                        clr_ptr <= 8'h00;
                        state <= ST_CLEAR;
                    end else if (start) begin
                        // Newest sample sits at wptr; walk from the oldest tap
                        rptr <= ptr_add(wptr, DATA_DEPTH - fir_taps_minus_one);
                        cptr <= fir_coefficient_start_offset;
                        tap_left <= fir_taps_minus_one;
                        acc_i <= '0;
                        acc_q <= '0;
                        state <= ST_MAC;
                    end
                end
                ST_MAC: begin
                    acc_i <= acc_i + ACC_W'(di * cf);
                    acc_q <= acc_q + ACC_W'(dq * cf);
                    rptr <= ptr_add(rptr, 8'h01);
                    cptr <= cptr + 8'h01;
                    tap_left <= tap_left - 8'h01;
                    if (tap_left == 8'h00) begin
                        out_valid <= 1'b1;
                        out_i <= sat_out(acc_i + ACC_W'(di * cf));
                        out_q <= sat_out(acc_q + ACC_W'(dq * cf));
                        state <= ST_IDLE;
                    end
                end
                ST_CLEAR: begin
                    clr_ptr <= clr_ptr + 8'h01;
                    if (clr_ptr == DATA_DEPTH - 8'h01) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== comb_fir_channel_sva.sv ====
// Checker for the comb and FIR channel back end: register bus handshake and output stream.
// Sees only the top module ports; bound into every instance at the foot of this file.
`timescale 1ns/1ps
module comb_fir_channel_sva #(
    parameter int OUT_W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic in_valid,
    input wire logic out_valid,
    input wire logic [OUT_W-1:0] out_i,
    input wire logic [OUT_W-1:0] out_q
);
    // Cycles since the last accepted sample, saturating so long idles never wrap
    logic [9:0] idle_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt <= 10'h000;
        end else if (in_valid) begin
            idle_cnt <= 10'h000;
        end else if (idle_cnt != 10'h3ff) begin
            idle_cnt <= idle_cnt + 10'h001;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_setup_answer;
        s_setup |=> s_access;
    endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("no ready after setup");
    property p_ready_pulse;
        s_access |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past access");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error without ready or with data");
    property p_idle_prdata;
        !psel && !$past(psel) |-> prdata == 32'h0;
    endproperty
    a_idle_prdata: assert property (p_idle_prdata) else $error("read data not zero when idle");
    property p_out_pulse;
        out_valid |=> !out_valid;
    endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("output strobe longer than one cycle");
    property p_out_hold;
        !out_valid |-> $stable(out_i) && $stable(out_q);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output changed without strobe");
    property p_out_cause;
        out_valid |-> idle_cnt <= 10'd165;
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("output with no recent sample");
endmodule
bind comb_fir_channel comb_fir_channel_sva #(.OUT_W(OUT_W)) i_sva (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .in_valid, .out_valid, .out_i, .out_q);

// ==== comb_fir_partner.sv ====
// Model of the upstream resampling stage and the downstream output formatter.
// Assumes the same pclk and presetn as the channel; gap 0 stops the sample stream.
`timescale 1ns/1ps
module comb_fir_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] gap,
    input wire logic [19:0] src_i,
    input wire logic [19:0] src_q,
    output logic in_valid,
    output logic [19:0] in_i,
    output logic [19:0] in_q,
    input wire logic out_valid,
    input wire logic [23:0] out_i,
    input wire logic [23:0] out_q,
    output logic [15:0] n_out,
    output logic [23:0] last_i,
    output logic [23:0] last_q
);
    logic [7:0] wait_cnt;
    // One sample per gap cycles, never faster than one per clock; data toggles between samples
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid <= 1'b0;
            wait_cnt <= 8'h00;
            in_i <= 20'h00000;
            in_q <= 20'h00000;
        end else if (gap != 8'h00 && wait_cnt == 8'h00) begin
            in_valid <= 1'b1;
            wait_cnt <= gap - 8'h01;
            in_i <= src_i;
            in_q <= src_q;
        end else begin
            in_valid <= 1'b0;
            wait_cnt <= (wait_cnt == 8'h00) ? 8'h00 : wait_cnt - 8'h01;
            in_i <= ~in_i;
            in_q <= ~in_q;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_out <= 16'h0000;
            last_i <= 24'h000000;
            last_q <= 24'h000000;
        end else if (out_valid) begin
            n_out <= n_out + 16'h0001;
            last_i <= out_i;
            last_q <= out_q;
        end
    end
endmodule

// ==== comb_fir_channel_tb.sv ====
// Self-checking bench for the comb and FIR channel: registers over APB, decimation timing, filter values.
// Assumes the partner model for the sample stream and the checker bound in by its own file.
`timescale 1ns/1ps
module comb_fir_channel_tb;
    import comb_fir_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, d;
    logic pready, pslverr, in_valid, out_valid, e;
    logic [19:0] in_i, in_q;
    logic [23:0] out_i, out_q, last_i, last_q;
    logic [7:0] gap = 8'h00;
    logic [19:0] src_i = 20'h10000;
    logic [19:0] src_q = 20'h08000;
    logic [15:0] n_out, n0;
    int n_errors = 0;
    int n_compared = 0;
    int t;
    int t_first [3];
    always #2.5 pclk = ~pclk;
    comb_fir_channel i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .in_valid, .in_i, .in_q, .out_valid, .out_i, .out_q);
    comb_fir_partner i_partner (.pclk, .presetn, .gap, .src_i, .src_q, .in_valid, .in_i, .in_q,
        .out_valid, .out_i, .out_q, .n_out, .last_i, .last_q);
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, wd, rd, err);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0, rd, err);
        check(what, exp, rd);
        check({what, " error"}, {31'h0, exp_err}, {31'h0, err});
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic clear_ram;
        wr(IDX_COMB_CONFIG, 32'h0001_0002);
        t = 0;
        do begin
            apb(1'b0, IDX_STATUS, 32'h0, d, e);
            t++;
        end while (d[1] !== 1'b0 && t < 400);
        check("clear finished", 32'h0, {31'h0, d[1]});
        check("pointer after clear", 32'h0, {24'h0, d[15:8]});
    endtask
    task complete_run;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Register tables: index, reset value, written value, value read back after clamping
    logic [7:0] r_idx [6] = '{IDX_FIR_DEC, IDX_FIR_PHASE, IDX_FIR_TAPS, IDX_FIR_OFFSET, IDX_COMB_CONFIG, IDX_COMB_CONFIG};
    logic [31:0] r_rst [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h2};
    logic [31:0] r_wr [6] = '{32'h5a, 32'hc3, 32'hff, 32'h81, 32'h1928, 32'h1};
    logic [31:0] r_exp [6] = '{32'h5a, 32'hc3, 32'h9f, 32'h81, 32'h1420, 32'h2};
    // Filter cases: comb ratio, comb scale, coefficient at tap 128, expected I and Q
    logic [5:0] v_rat [4] = '{6'h02, 6'h20, 6'h02, 6'h02};
    logic [4:0] v_sc [4] = '{5'h00, 5'h14, 5'h01, 5'h00};
    logic [31:0] v_c [4] = '{32'h10000, 32'h10000, 32'h10000, 32'hf0000};
    logic [23:0] v_i [4] = '{24'h030000, 24'h030000, 24'h018000, 24'hff0000};
    logic [23:0] v_q [4] = '{24'h018000, 24'h018000, 24'h00c000, 24'hff8000};
    logic [7:0] d_dec [3] = '{8'h03, 8'h03, 8'hff};
    logic [7:0] d_ph [3] = '{8'h00, 8'h03, 8'h00};
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
    initial begin
        do_reset();
        for (int k = 0; k < 5; k++) rd_chk("reset value", r_idx[k], r_rst[k], 1'b0);
        for (int k = 0; k < 6; k++) begin
            wr(r_idx[k], r_wr[k]);
            rd_chk("readback", r_idx[k], r_exp[k], 1'b0);
        end
        wr(8'h90, 32'h5a);
        rd_chk("unmapped", 8'h90, 32'h0, 1'b1);
        // Zero coefficient 0 and the data RAM so the rate runs never sum unknown words
        wr(8'h00, 32'h0);
        clear_ram();
        // Phase and rate: same reset state each run, one sample per clock, comb ratio 2
        for (int k = 0; k < 3; k++) begin
            do_reset();
            wr(IDX_FIR_DEC, {24'h0, d_dec[k]});
            wr(IDX_FIR_PHASE, {24'h0, d_ph[k]});
            gap <= 8'h01;
            t = 0;
            while (n_out == 16'h0 && t < 4000) begin
                @(posedge pclk);
                t++;
            end
            t_first[k] = t;
            n0 = n_out;
            repeat (8 * (int'(d_dec[k]) + 1)) @(posedge pclk);
            check("outputs per four periods", 32'd4, {16'h0, n_out - n0});
            gap <= 8'h00;
        end
        check("phase lead in cycles", 32'(2 * 3), 32'(t_first[0] - t_first[1]));
        do_reset();
        clear_ram();
        wr(IDX_FIR_DEC, 32'h3);
        wr(IDX_FIR_TAPS, 32'h1);
        wr(IDX_FIR_OFFSET, 32'h7f);
        wr(IDX_FIR_CONTROL, 32'h0);
        wr(IDX_COEF_LAST, 32'h08000);
        wr(IDX_FIR_CONTROL, 32'h100);
        rd_chk("page select", IDX_FIR_CONTROL, 32'h100, 1'b0);
        for (int k = 0; k < 4; k++) begin
            // Cases 0, 1 and 3 pick the scale for unity comb gain; case 2 adds one step and halves the output
            wr(IDX_COMB_CONFIG, {19'h0, v_sc[k], 2'b00, v_rat[k]});
            wr(8'h00, v_c[k]);
            gap <= 8'h01;
            repeat (400) @(posedge pclk);
            gap <= 8'h00;
            repeat (20) @(posedge pclk);
            check("filter out_i", {8'h0, v_i[k]}, {8'h0, last_i});
            check("filter out_q", {8'h0, v_q[k]}, {8'h0, last_q});
        end
        // Coefficients read back sign-extended from 20 bits
        rd_chk("coefficient readback", 8'h00, 32'hffff0000, 1'b0);
        complete_run();
    end
endmodule
